// [src/msm_mdio_eng.sv]
`timescale 1ns/1ps
module msm_mdio_eng (
    input  wire logic                    mclk,    // System clock
    input  wire logic                    rst,     // Async reset, high
    input  wire logic                    start,   // Begin one frame
    input  wire logic                    write,   // 1 write, 0 read
    input  wire logic [msm_pkg::SEL_W-1:0] phy_sel, // PHY address
    input  wire logic [msm_pkg::SEL_W-1:0] reg_sel, // Register address
    input  wire logic [msm_pkg::MD_W-1:0]  wdata,   // Write payload
    output logic                         busy,    // Frame in progress
    output logic                         done,    // Last bit pulse
    output logic [msm_pkg::MD_W-1:0]     rdata,   // Read payload
    output logic                         mdc,     // Management clock
    output logic                         mdio_o,  // Data out
    output logic                         mdio_oe, // High while driving
    input  wire logic                    mdio_i   // Data pin in
);
    import msm_pkg::*;

    msm_eng_st_t             st_r;        // Engine state
    logic [DIV_W-1:0]        div_r;       // Half period counter
    logic [CNT_W-1:0]        bit_r;       // Bit position in frame
    logic [FRAME_BITS-1:0]   sh_r;        // Outgoing frame
    logic                    wr_r;        // Latched direction
    logic                    mdc_r;       // Clock level
    logic [MD_W-1:0]         rd_r;        // Read shift
    logic                    s1_r;        // Sync stage one
    logic                    s2_r;        // Sync stage two

    wire run  = (st_r == MSM_RUN);
    wire tick = (div_r == DIV_W'(MDC_HALF_CYC - 1));
    wire rise = run && tick && !mdc_r;
    wire fall = run && tick && mdc_r;
    wire last = fall && (bit_r == CNT_W'(FRAME_BITS - 1));
    // Data bits follow the turnaround
    wire samp = rise && !wr_r && (bit_r >= CNT_W'(HDR_BITS + TA_BITS));
    wire [FRAME_BITS-1:0] frame = {PREAMBLE, FR_START, write ? OP_WRITE : OP_READ,
                                   phy_sel, reg_sel, write ? TA_WRITE : TA_READ, wdata};

    assign busy    = run;                                        // RULE_04
    assign done    = last;
    assign rdata   = rd_r;
    assign mdc     = mdc_r;
    assign mdio_o  = sh_r[FRAME_BITS-1];
    // Release the line for turnaround and data on reads
    assign mdio_oe = run && (wr_r || bit_r < CNT_W'(HDR_BITS));  // RULE_03

    // Pin synchroniser; only stage two is read
    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            s1_r <= 1'b0;
            s2_r <= 1'b0;
        end
        else
        begin
            s1_r <= mdio_i;
            s2_r <= s1_r;
        end
    end

    // Frame sequencer: shift on falling MDC, sample on rising
    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            st_r  <= MSM_IDLE;
            div_r <= '0;
            bit_r <= '0;
            sh_r  <= '0;
            wr_r  <= 1'b0;
            mdc_r <= 1'b0;
            rd_r  <= '0;
        end
        else if (!run)
        begin
            div_r <= '0;
            bit_r <= '0;
            mdc_r <= 1'b0;
            if (start)
            begin
                st_r <= MSM_RUN;                                 // RULE_11
                sh_r <= frame;                                   // RULE_01 RULE_02
                wr_r <= write;
            end
        end
        else
        begin
            div_r <= tick ? '0 : div_r + 1'b1;
            if (tick)
                mdc_r <= !mdc_r;
            if (samp)
                rd_r <= {rd_r[MD_W-2:0], s2_r};                  // RULE_06
            if (fall)
            begin
                bit_r <= bit_r + 1'b1;
                sh_r  <= {sh_r[FRAME_BITS-2:0], 1'b0};
            end
            if (last)
                st_r <= MSM_IDLE;                                // RULE_04
        end
    end
endmodule

// [src/msm_pkg.sv]
// What this block does
// (RULE_01) Five-bit PHY select in command bits 15:11
// (RULE_02) Five-bit register select in bits 10:6
// (RULE_03) Direction bit one writes, zero reads
// (RULE_04) Busy flag high for whole transaction
// (RULE_05) Host checks busy clear before new command
// (RULE_06) Data word sent on write, filled on read
// (RULE_07) Host loads upper address bytes high register
// (RULE_08) Host loads lower four bytes low register
// (RULE_09) Host reaches registers only through indirect addressing
// (RULE_10) Pause time field drives transmitted pause frames
// (RULE_11) Each command runs one clause 22 frame
package msm_pkg;
    // Indirect register port
    localparam int ADDR_W = 16;
    localparam int DATA_W = 32;
    localparam logic [ADDR_W-1:0] OFF_SA_HIGH = 16'h0004;
    localparam logic [ADDR_W-1:0] OFF_SA_LOW  = 16'h0008;
    localparam logic [ADDR_W-1:0] OFF_CMD     = 16'h0014;
    localparam logic [ADDR_W-1:0] OFF_DATA    = 16'h0018;
    localparam logic [ADDR_W-1:0] OFF_FCR     = 16'h001c;
    // Reset values
    localparam logic [DATA_W-1:0] RST_SA_HIGH = 32'hffff_ffff;
    localparam logic [DATA_W-1:0] RST_SA_LOW  = 32'hffff_ffff;
    localparam logic [DATA_W-1:0] RST_CMD     = 32'h0000_5ac0;
    localparam logic [DATA_W-1:0] RST_DATA    = 32'h0000_0000;
    localparam logic [DATA_W-1:0] RST_FCR     = 32'h0050_0002;
    // Writable bit masks
    localparam logic [DATA_W-1:0] MASK_CMD    = 32'h0000_ffc2;
    localparam logic [DATA_W-1:0] MASK_DATA   = 32'h0000_ffff;
    localparam logic [DATA_W-1:0] MASK_FCR    = 32'hffff_0002;
    // Command fields
    localparam int PHY_MSB = 15;
    localparam int PHY_LSB = 11;
    localparam int REG_MSB = 10;
    localparam int REG_LSB = 6;
    localparam int DIR_BIT = 1;
    localparam int BUSY_BIT = 0;
    localparam int SEL_W = 5;
    localparam int MD_W = 16;
    // Flow control fields
    localparam int PQ_MSB = 31;
    localparam int PQ_LSB = 16;
    localparam int FCE_BIT = 1;
    localparam int FCB_BIT = 0;
    localparam int SA_HI_W = 16;
    localparam int SA_W = 48;
    // Management frame layout
    localparam int FRAME_BITS = 64;
    localparam int HDR_BITS = 46;
    localparam int TA_BITS = 2;
    localparam int CNT_W = 6;
    localparam logic [31:0] PREAMBLE = 32'hffff_ffff;
    localparam logic [1:0] FR_START  = 2'h1;
    localparam logic [1:0] OP_WRITE  = 2'h1;
    localparam logic [1:0] OP_READ   = 2'h2;
    localparam logic [1:0] TA_WRITE  = 2'h2;
    localparam logic [1:0] TA_READ   = 2'h3;
    // Timing: management clock made by dividing mclk
    localparam int MCLK_PERIOD_NS = 10;
    localparam int MDC_PERIOD_NS = 160;
    localparam int MDC_HALF_CYC = MDC_PERIOD_NS / (2 * MCLK_PERIOD_NS);
    localparam int DIV_W = 4;
    // Engine states
    typedef enum logic {MSM_IDLE, MSM_RUN} msm_eng_st_t;
endpackage

// [src/msm_top.sv]
`timescale 1ns/1ps
module msm_top (
    input  wire logic                       mclk,          // 100 MHz clock
    input  wire logic                       rst,           // Async reset, high
    input  wire logic [msm_pkg::ADDR_W-1:0] ind_addr,      // Indirect offset
    input  wire logic [msm_pkg::DATA_W-1:0] ind_wdata,     // Write data
    input  wire logic                       ind_wr,        // Write strobe
    input  wire logic                       ind_rd,        // Read strobe
    output logic [msm_pkg::DATA_W-1:0]      ind_rdata,     // Read data
    output logic                            ind_rvalid,    // Read data valid
    output logic [msm_pkg::SA_W-1:0]        station_address_bits, // Own address
    output logic [msm_pkg::MD_W-1:0]        pause_quanta_field,   // Pause time
    output logic                            flow_ctrl_en,  // Auto flow control
    output logic                            pause_req,     // Send pause frame
    input  wire logic                       pause_done,    // Pause frame sent
    output logic                            mdc,           // Management clock
    output logic                            mdio_o,        // Management data out
    output logic                            mdio_oe,       // Drive enable
    input  wire logic                       mdio_i         // Management data in
);
    import msm_pkg::*;

    logic [DATA_W-1:0] sah_r;    // Station address high
    logic [DATA_W-1:0] sal_r;    // Station address low
    logic [DATA_W-1:0] cmd_r;    // Management command
    logic [DATA_W-1:0] dat_r;    // Management data word
    logic [DATA_W-1:0] fcr_r;    // Flow control
    logic [DATA_W-1:0] rdat_r;   // Read answer
    logic              rval_r;   // Read answer valid
    logic              eng_busy; // Engine busy
    logic              eng_done; // Engine done pulse
    logic [MD_W-1:0]   eng_rdata;// Engine read result
    logic [DATA_W-1:0] fcr_nxt;  // Flow control next
    logic [DATA_W-1:0] rd_nxt;   // Read mux

    // Address decode; all access goes through the indirect port
    wire hit_sah = (ind_addr == OFF_SA_HIGH);                    // RULE_09
    wire hit_sal = (ind_addr == OFF_SA_LOW);
    wire hit_cmd = (ind_addr == OFF_CMD);
    wire hit_dat = (ind_addr == OFF_DATA);
    wire hit_fcr = (ind_addr == OFF_FCR);
    wire hit_none = !(hit_sah || hit_sal || hit_cmd || hit_dat || hit_fcr); // Unmapped offset
    // A command written while busy is dropped, so a frame is never cut short
    wire start   = ind_wr && hit_cmd && !eng_busy;               // RULE_05 RULE_11
    // Only a read frame hands data back to the data register
    wire rd_back = eng_done && !cmd_r[DIR_BIT];
    // Host may set the pause request; only the frame sender clears it
    wire fcb_set = ind_wr && hit_fcr && ind_wdata[FCB_BIT];
    wire fcb_nxt = fcb_set || (fcr_r[FCB_BIT] && !pause_done);

    assign fcr_nxt = {(ind_wr && hit_fcr) ? (ind_wdata[DATA_W-1:FCB_BIT+1]
                      & MASK_FCR[DATA_W-1:FCB_BIT+1]) : fcr_r[DATA_W-1:FCB_BIT+1], fcb_nxt};
    // Busy is live engine state, not a stored bit
    assign rd_nxt = hit_sah ? sah_r :
                    hit_sal ? sal_r :
                    hit_cmd ? {cmd_r[DATA_W-1:BUSY_BIT+1], eng_busy} :   // RULE_04
                    hit_dat ? dat_r :
                    hit_fcr ? fcr_r : '0;

    // Outputs straight from registers
    assign ind_rdata  = rdat_r;
    assign ind_rvalid = rval_r;
    assign station_address_bits = {sah_r[SA_HI_W-1:0], sal_r};   // RULE_07 RULE_08
    assign pause_quanta_field   = fcr_r[PQ_MSB:PQ_LSB];          // RULE_10
    assign flow_ctrl_en         = fcr_r[FCE_BIT];
    assign pause_req            = fcr_r[FCB_BIT];

    // Register file
    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            sah_r <= RST_SA_HIGH;
            sal_r <= RST_SA_LOW;
            cmd_r <= RST_CMD;
            dat_r <= RST_DATA;
            fcr_r <= RST_FCR;
        end
        else
        begin
            // Station address halves take whole words
            if (ind_wr && hit_sah)
                sah_r <= ind_wdata;                              // RULE_07
            if (ind_wr && hit_sal)
                sal_r <= ind_wdata;                              // RULE_08
            // Command fields latch only when a frame really starts
            if (start)
                cmd_r <= ind_wdata & MASK_CMD;                   // RULE_01 RULE_02 RULE_03
            // Returned read data wins over a host write in the same cycle
            if (rd_back)
                dat_r <= {{(DATA_W-MD_W){1'b0}}, eng_rdata};     // RULE_06
            else if (ind_wr && hit_dat)
                dat_r <= ind_wdata & MASK_DATA;
            // Flow control moves every cycle: host write or pause handshake
            fcr_r <= fcr_nxt;                                    // RULE_10
        end
    end

    // Read answer one cycle after the strobe; unmapped reads as zero
    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            rdat_r <= '0;
            rval_r <= 1'b0;
        end
        else
        begin
            rval_r <= ind_rd;
            // Data holds between reads; valid pulses once per strobe
            if (ind_rd)
                rdat_r <= rd_nxt;
        end
    end

    // Serial management engine, command fields fed straight from the write data, payload from the data register
    msm_mdio_eng u_eng (
        .mclk    (mclk),
        .rst     (rst),
        .start   (start),
        .write   (ind_wdata[DIR_BIT]),
        .phy_sel (ind_wdata[PHY_MSB:PHY_LSB]),
        .reg_sel (ind_wdata[REG_MSB:REG_LSB]),
        .wdata   (dat_r[MD_W-1:0]),
        .busy    (eng_busy),
        .done    (eng_done),
        .rdata   (eng_rdata),
        .mdc     (mdc),
        .mdio_o  (mdio_o),
        .mdio_oe (mdio_oe),
        .mdio_i  (mdio_i)
    );

    // Assertion helpers: frame length in mclk cycles, and where reads let go
    localparam int FRAME_CYC   = FRAME_BITS * 2 * MDC_HALF_CYC;
    localparam int RELEASE_CYC = HDR_BITS * 2 * MDC_HALF_CYC;
    localparam int CYC_W       = $clog2(FRAME_CYC + 1);

    logic [CYC_W-1:0] frame_cyc_r; // Cycles since the frame began

    // Counts only while busy, so it gives the position inside the frame
    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
            frame_cyc_r <= '0;
        else if (!eng_busy)
            frame_cyc_r <= '0;                      // Idle: ready for the next frame
        else
            frame_cyc_r <= frame_cyc_r + 1'b1;      // One more cycle of the frame
    end

    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);

    // Command fields captured as the frame starts
    cmd_phy_a: assert property (start |=> eng_busy &&                    // RULE_01
        cmd_r[PHY_MSB:PHY_LSB] == $past(ind_wdata[PHY_MSB:PHY_LSB]))
        else $error("phy select not captured");
    cmd_reg_a: assert property (start |=> eng_busy &&                    // RULE_02
        cmd_r[REG_MSB:REG_LSB] == $past(ind_wdata[REG_MSB:REG_LSB]))
        else $error("register select not captured");
    dir_drive_a: assert property (eng_busy && cmd_r[DIR_BIT] |-> mdio_oe) // RULE_03
        else $error("write frame released the line");
    busy_hold_a: assert property (start |=> eng_busy [*8])               // RULE_04
        else $error("busy dropped early");
    busy_clear_a: assert property (eng_done |=>                          // RULE_04
        !eng_busy && (!rd_nxt[BUSY_BIT] || !hit_cmd))
        else $error("busy not cleared after frame");
    busy_drop_a: assert property (eng_busy && ind_wr && hit_cmd |=>      // RULE_05
        $stable(cmd_r)) else $error("command overwritten while busy");
    read_back_a: assert property (rd_back |=>                            // RULE_06
        dat_r[MD_W-1:0] == $past(eng_rdata)) else $error("read data lost");
    // Station address and pause time loads
    addr_low_a: assert property (ind_wr && hit_sal |=>                   // RULE_08
        station_address_bits[DATA_W-1:0] == $past(ind_wdata))
        else $error("station low not loaded");
    pause_time_a: assert property (ind_wr && hit_fcr |=>                 // RULE_10
        pause_quanta_field == $past(ind_wdata[PQ_MSB:PQ_LSB]))
        else $error("pause time not loaded");

    // Management clock and data timing
    mdc_idle_a: assert property (!eng_busy |-> !mdc)                     // RULE_11
        else $error("clock runs outside a frame");
    mdc_high_a: assert property ($rose(mdc) |-> mdc [*8] ##1 !mdc)       // RULE_11
        else $error("clock high phase not eight cycles");
    mdc_low_a: assert property ($fell(mdc) && eng_busy |->               // RULE_11
        !mdc [*8] ##1 mdc) else $error("clock low phase not eight cycles");
    mdio_shift_a: assert property (eng_busy && $past(eng_busy) &&        // RULE_11
        $changed(mdio_o) |-> $fell(mdc)) else $error("data moved off the falling clock");

    // Frame timing, counted from the start edge
    frame_len_a: assert property (eng_done |->                           // RULE_11
        frame_cyc_r == CYC_W'(FRAME_CYC - 1)) else $error("frame length wrong");
    frame_bound_a: assert property (eng_busy |->                         // RULE_04
        frame_cyc_r < CYC_W'(FRAME_CYC)) else $error("busy outlasted one frame");
    read_release_a: assert property (eng_busy && !cmd_r[DIR_BIT] &&      // RULE_03
        frame_cyc_r >= CYC_W'(RELEASE_CYC) |-> !mdio_oe)
        else $error("read frame kept driving the line");

    // Register port answers
    rd_valid_a: assert property (ind_rd |=> ind_rvalid)                  // RULE_09
        else $error("read answer missing");
    unmapped_rd_a: assert property (ind_rd && hit_none |=> ind_rdata == '0) // RULE_09
        else $error("unmapped read not zero");
    addr_high_a: assert property (ind_wr && hit_sah |=>                  // RULE_07
        station_address_bits[SA_W-1:DATA_W] == $past(ind_wdata[SA_HI_W-1:0]))
        else $error("station high not loaded");
    data_load_a: assert property (ind_wr && hit_dat && !rd_back |=>      // RULE_06
        dat_r == $past(ind_wdata & MASK_DATA)) else $error("data word not loaded");

    // Pause request: host sets it, the frame sender clears it
    pause_set_a: assert property (fcb_set |=> pause_req)                 // RULE_10
        else $error("pause request not set");
    pause_clear_a: assert property (pause_done && !fcb_set |=>           // RULE_10
        !pause_req) else $error("pause request not cleared");

    // Main scenarios; a frame outlasts the widest range, so a plain delay leads in
    read_frame_c: cover property (start && !ind_wdata[DIR_BIT] ##300 eng_busy ##[1:1000] rd_back);
    write_frame_c: cover property (start && ind_wdata[DIR_BIT] ##300 eng_busy
        ##[1:1000] eng_done);
    pause_c: cover property (fcb_set ##[1:20] pause_done);
    refuse_c: cover property (eng_busy && ind_wr && hit_cmd);
    release_c: cover property (eng_busy && !cmd_r[DIR_BIT] && !mdio_oe);
endmodule

// [test/msm_phy_model.sv]
`timescale 1ns/1ps
// Behavioural management-bus PHY: shifts in every frame bit on mdc rising
// edges and answers read frames with rd_val, msb first.
module msm_phy_model (
    input  wire logic        mdc,        // Management clock from the device
    input  wire logic        rst,        // Async reset, high
    input  wire logic        mdio,       // Resolved wire level
    input  wire logic [15:0] rd_val,     // Value returned on reads
    output logic             drv_oe,     // High while the PHY drives the wire
    output logic             drv_d,      // PHY data onto the wire
    output logic [63:0]      last_frame, // Last whole frame as seen on the wire
    output int               n_frames    // Count of completed frames
);
    logic [63:0] sh;    // Bits of the frame in flight
    int          k;     // Bit index inside the frame
    logic        is_rd; // Opcode of the frame in flight was a read

    // Frames are a fixed 64 clocks, so a plain bit counter keeps framing;
    // no preamble hunt is needed since mdc stands still between frames
    always @(posedge mdc or posedge rst)
    begin
        if (rst)
        begin
            sh = '0; k = 0; is_rd = 1'b0; drv_oe = 1'b0; drv_d = 1'b0;
            last_frame = '0; n_frames = 0;
        end
        else
        begin
            sh = {sh[62:0], mdio};
            // Opcode sits at bits 34 and 35
            if (k == 35)
                is_rd = (sh[1:0] == 2'b10);
            // Bit 46 left to the pull-up, then zero, then 16 data bits
            if (is_rd && k >= 46 && k <= 62)
            begin
                drv_oe = 1'b1;
                drv_d  = (k == 46) ? 1'b0 : rd_val[62 - k];
            end
            if (k == 63)
            begin
                last_frame = sh; n_frames++; k = 0; is_rd = 1'b0; drv_oe = 1'b0;
                drv_d = ~drv_d; // Released: drive level inverted, not cleared
            end
            else
                k++;
        end
    end
endmodule

// [test/tb_top.sv]
`timescale 1ns/1ps
module tb_top;
    import msm_pkg::*;
    logic              mclk, rst, ind_wr, ind_rd, pause_done; // Driven inputs
    logic              ind_rvalid, mdc, mdio_o, mdio_oe;      // Observed outputs
    logic              flow_ctrl_en, pause_req, phy_oe, phy_d; // Flow and PHY pins
    logic [ADDR_W-1:0] ind_addr;                   // Register offset
    logic [DATA_W-1:0] ind_wdata, ind_rdata, rv;   // Write, read, last read
    logic [SA_W-1:0]   sa_bits;                    // Station address out
    logic [MD_W-1:0]   pq, rd_val;                 // Pause time, PHY answer
    logic [63:0]       frame;                      // Last frame seen by PHY
    int                n_frames, mismatches, n_checks; // Counters
    logic [ADDR_W-1:0] offs [6] = '{OFF_SA_HIGH, OFF_SA_LOW, OFF_CMD, OFF_DATA, OFF_FCR, 16'h0000};
    logic [DATA_W-1:0] rsts [6] = '{RST_SA_HIGH, RST_SA_LOW, RST_CMD, RST_DATA, RST_FCR, 32'h0};
    // Wire level: device, else PHY, else the pull-up
    wire logic         mdio_i = mdio_oe ? mdio_o : (phy_oe ? phy_d : 1'b1);

    msm_top i_dut (.mclk(mclk), .rst(rst), .ind_addr(ind_addr), .ind_wdata(ind_wdata),
        .ind_wr(ind_wr), .ind_rd(ind_rd), .ind_rdata(ind_rdata), .ind_rvalid(ind_rvalid),
        .station_address_bits(sa_bits), .pause_quanta_field(pq), .flow_ctrl_en(flow_ctrl_en),
        .pause_req(pause_req), .pause_done(pause_done), .mdc(mdc), .mdio_o(mdio_o),
        .mdio_oe(mdio_oe), .mdio_i(mdio_i));
    msm_phy_model i_phy (.mdc(mdc), .rst(rst), .mdio(mdio_i), .rd_val(rd_val),
        .drv_oe(phy_oe), .drv_d(phy_d), .last_frame(frame), .n_frames(n_frames));

    // Compare and count
    task automatic chk(input string what, input logic [63:0] exp, input logic [63:0] got);
        n_checks++;
        if (got !== exp)
        begin
            mismatches++;
            $display("unexpected %s: expected %h seen %h", what, exp, got);
        end
    endtask
    // One write strobe, inputs moved on falling edges only
    task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
        @(negedge mclk);
        ind_addr = a; ind_wdata = d; ind_wr = 1'b1;
        @(negedge mclk);
        ind_wr = 1'b0;
    endtask
    // One read strobe; the answer stands in the following cycle
    task automatic rd(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] d);
        @(negedge mclk);
        ind_addr = a; ind_rd = 1'b1;
        @(negedge mclk);
        ind_rd = 1'b0;
        chk("read valid", 64'd1, {63'd0, ind_rvalid});
        d = ind_rdata;
    endtask
    // Poll busy, bounded so a stuck flag cannot hang the run
    task automatic wait_idle();
        int i;
        for (i = 0; i < 1000; i++)
        begin
            rd(OFF_CMD, rv);
            if (rv[BUSY_BIT] === 1'b0)
                break;
        end
        chk("busy clears in time", 64'd1, {63'd0, i < 1000});
    endtask
    // Single exit for the normal end and the watchdog
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", n_checks, mismatches);
        if (mismatches == 0 && n_checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    // 100 MHz clock
    initial
    begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end
    // Two frames take about 2100 cycles; this is ample headroom
    initial
    begin
        repeat (20000) @(posedge mclk);
        mismatches++;
        wrap_up();
    end
    // Main sequence
    initial
    begin
        rst = 1'b0; ind_addr = '0; ind_wdata = '0; ind_wr = 1'b0; ind_rd = 1'b0;
        pause_done = 1'b0; rd_val = 16'h3c5a; mismatches = 0; n_checks = 0;
        #1 rst = 1'b1; // A real rising edge, so the PHY model resets as well
        repeat (16) @(negedge mclk);
        rst = 1'b0;
        for (int i = 0; i < 6; i++)
        begin
            rd(offs[i], rv);
            chk("reset value", {32'h0, rsts[i]}, {32'h0, rv});
        end
        chk("station address reset", {16'h0, {SA_W{1'b1}}}, {16'h0, sa_bits});
        wr(OFF_SA_HIGH, 32'h1234_abcd);
        wr(OFF_SA_LOW, 32'h5566_7788);
        chk("station address", 64'h0000_abcd_5566_7788, {16'h0, sa_bits});
        rd(OFF_SA_HIGH, rv);
        chk("address high readback", 64'h1234_abcd, {32'h0, rv});
        wr(16'h0100, 32'hffff_ffff);
        rd(16'h0100, rv);
        chk("unmapped read", 64'h0, {32'h0, rv});
        // Management write, plus a second command refused mid-frame
        wr(OFF_DATA, 32'h0000_a5c3);
        wr(OFF_CMD, {16'h0, 5'h13, 5'h0a, 4'h0, 2'b10});
        rd(OFF_CMD, rv);
        chk("busy while running", 64'h0000_9a83, {32'h0, rv});
        wr(OFF_CMD, {16'h0, 5'h01, 5'h02, 6'h00});
        wait_idle();
        chk("command after write", 64'h0000_9a82, {32'h0, rv});
        chk("write frame", {32'hffff_ffff, FR_START, OP_WRITE, 5'h13, 5'h0a, TA_WRITE,
            16'ha5c3}, frame);
        chk("frames after write", 64'd1, 64'(n_frames));
        // Management read at the top register and a low PHY
        wr(OFF_CMD, {16'h0, 5'h05, 5'h1f, 6'h00});
        wait_idle();
        chk("read frame", {32'hffff_ffff, FR_START, OP_READ, 5'h05, 5'h1f, 2'b10,
            16'h3c5a}, frame);
        rd(OFF_DATA, rv);
        chk("read data", 64'h3c5a, {32'h0, rv});
        chk("frames after read", 64'd2, 64'(n_frames));
        chk("clock idle low", 64'd0, {63'd0, mdc});
        // Flow control fields and pause handshake
        wr(OFF_FCR, 32'h1234_0003);
        chk("pause time", 64'h1234, {48'h0, pq});
        chk("pause request", 64'd3, {62'd0, flow_ctrl_en, pause_req});
        @(negedge mclk);
        pause_done = 1'b1;
        @(negedge mclk);
        pause_done = 1'b0;
        @(negedge mclk);
        rd(OFF_FCR, rv);
        chk("flow control after pause", 64'h1234_0002, {32'h0, rv});
        wrap_up();
    end
endmodule
